// ===== verilog/rmd_map.svh
`ifndef RMD_MAP_SVH
`define RMD_MAP_SVH

// ==========================================
// Register offsets
`define RMD_ADDR_CTRL 8'h00
`define RMD_ADDR_CYCLE 8'h04
`define RMD_ADDR_MIN_ON 8'h08
`define RMD_ADDR_MAX_FREQ 8'h0c
`define RMD_ADDR_DIAG_MODE 8'h10
`define RMD_ADDR_ASSIGN_RELAY 8'h14
`define RMD_ADDR_ASSIGN_ALARM 8'h18
`define RMD_ADDR_CLASS_MAP 8'h1c
`define RMD_ADDR_ATTRIB 8'h20
`define RMD_ADDR_STATUS 8'h24

// ==========================================
// Field positions
`define RMD_CTRL_FN_LSB 0
`define RMD_CTRL_SRC_LSB 2
`define RMD_CTRL_MODE_BIT 4
`define RMD_CTRL_ACT_LSB 5
`define RMD_DM_RELAY_LSB 0
`define RMD_DM_ALARM_LSB 4

// ==========================================
// Reset values and limits (times in 0.1 s)
`define RMD_CTRL_RST 7'h00
`define RMD_DIAG_MODE_RST 7'h00
`define RMD_CYCLE_RST 14'h0064
`define RMD_CYCLE_MAX 14'h2706
`define RMD_MIN_ON_RST 14'h0003
`define RMD_MIN_ON_MIN 14'h0003
`define RMD_FREQ_RST 8'h3c
`define RMD_FREQ_MIN 8'h01
`define RMD_FREQ_MAX 8'hb4
`define RMD_FULL_SCALE 10'h3e8

// ==========================================
// Timing
`define RMD_CLK_HZ 25000000
`define RMD_BASE_TICK_MS 10
`define RMD_BASE_TICK_CYCLES (`RMD_CLK_HZ / 1000 * `RMD_BASE_TICK_MS)
`define RMD_STEP_MS 100
`define RMD_STEP_BASE_TICKS (`RMD_STEP_MS / `RMD_BASE_TICK_MS)
`define RMD_HALF_MIN_MS 30000
`define RMD_HALF_MIN_TICKS (`RMD_HALF_MIN_MS / `RMD_BASE_TICK_MS)

`endif

// ===== verilog/rmd_pkg.sv
`default_nettype none
package rmd_pkg;
   typedef logic [7:0] rmd_addr_t;
   typedef logic [31:0] rmd_word_t;
   typedef logic signed [15:0] rmd_y_t;
   typedef logic [15:0] rmd_msg_t;
   typedef enum logic [1:0] {rmd_fn_off, rmd_fn_ctrl, rmd_fn_diag} rmd_func_t;
   typedef enum logic [1:0] {rmd_src_none, rmd_src_c1, rmd_src_c2} rmd_src_t;
   typedef enum logic [1:0] {rmd_act_none, rmd_act_neg, rmd_act_pos} rmd_act_t;
   typedef enum logic {rmd_pwm, rmd_pfm} rmd_mode_t;
   typedef enum logic {rmd_pfm_gap, rmd_pfm_pulse} rmd_pfm_state_t;
endpackage : rmd_pkg
`default_nettype wire

// ===== verilog/rmd_diag_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rmd_diag_if;
   logic [15:0] msg_active;
   logic [15:0] assign_mask;
   logic [31:0] class_map;
   logic by_class;
   logic [1:0] class_sel;
   logic trip;
   modport cfg (output msg_active, output assign_mask, output class_map, output by_class, output class_sel,
                input trip);
   modport eval (input msg_active, input assign_mask, input class_map, input by_class, input class_sel,
                 output trip);
endinterface : rmd_diag_if
`default_nettype wire

// ===== verilog/rmd_tick.sv
`timescale 1ns/10ps
`default_nettype none
// Divides an incoming pulse train by N
module rmd_tick #(
   parameter int unsigned N = 10
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic tick_in,
   output logic tick_out
);
   localparam int W = (N > 1) ? $clog2(N) : 1;
   logic [W-1:0] cnt;

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt == W'(N - 1)) begin
               cnt <= '0;
               tick_out <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end

   property p_tick_cause;
      @(posedge clk) disable iff (reset) tick_out |-> $past(tick_in) && ($past(cnt) == W'(N - 1));
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("tick without full count"); // [R17]
endmodule : rmd_tick
`default_nettype wire

// ===== verilog/rmd_diag.sv
`timescale 1ns/10ps
`default_nettype none
// Trip decision for one diagnostic relay
module rmd_diag (
   input wire logic clk,
   input wire logic reset,
   rmd_diag_if.eval dif
);
   import rmd_pkg::*;
   logic [15:0] sel_mask;

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_msg
         // Class match or individual assignment
         assign sel_mask[i] = dif.by_class ? (dif.class_map[2*i +: 2] == dif.class_sel)
                                           : dif.assign_mask[i]; // [R13] [R14]
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (reset) begin
         dif.trip <= 1'b0;
      end else begin
         dif.trip <= |(dif.msg_active & sel_mask); // [R13] [R14]
      end
   end

   property p_trip_cause;
      @(posedge clk) disable iff (reset)
         ($past(!dif.by_class) && !$past(reset)) |-> (dif.trip == |($past(dif.msg_active) & $past(dif.assign_mask)));
   endproperty
   a_trip_cause: assert property (p_trip_cause) else $error("assigned trip mismatch"); // [R13]
endmodule : rmd_diag
`default_nettype wire

// ===== verilog/rmd_top.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "rmd_map.svh"

// Overview of operation
// R01: PFM pulses fixed length, gap varies
// R02: At maximum rate gap equals pulse
// R03: Actuator part: none, negative or positive
// R04: PWM cycle up to 999.0 s, default 10
// R05: Cycle never below minimum on-time
// R06: Minimum on-time from 0.3 s, default 0.3
// R07: Pulses below minimum on-time are dropped (here only in PWM mode; PFM pulses are not checked against min_on)
// R08: PFM rate 1 to 180 per minute, default 60
// R09: PFM pulse length follows maximum rate
// R10: Diagnostic relay runs fail-safe
// R11: Energized without error, released on error
// R12: Alarm relay always fail-safe
// R13: Assigned mode trips on assigned messages
// R14: Four classes, remappable per message
// R15: Attributed message list is read-only
// R16: Modulated relay pulses then pauses
// R17: PWM period constant, duty varies
// R18: No part or source keeps relay off
module rmd_top #(
   parameter int unsigned BASE_TICK_CYCLES = `RMD_BASE_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire rmd_pkg::rmd_addr_t addr,
   input wire rmd_pkg::rmd_word_t wdata,
   input wire logic wr,
   input wire logic rd,
   output rmd_pkg::rmd_word_t rdata,
   input wire rmd_pkg::rmd_y_t ctrl1_y,
   input wire rmd_pkg::rmd_y_t ctrl2_y,
   input wire rmd_pkg::rmd_msg_t diag_msg_active,
   output logic relay_out,
   output logic alarm_relay_out
);
   import rmd_pkg::*;

   // ==========================================
   // Registers
   logic [6:0] ctrl;
   logic [13:0] cycle;
   logic [13:0] min_on;
   logic [7:0] max_freq;
   logic [6:0] diag_mode;
   logic [15:0] assign_relay;
   logic [15:0] assign_alarm;
   logic [31:0] class_map;
   logic [13:0] next_cycle;
   logic [13:0] next_min_on;
   logic [7:0] next_freq;

   rmd_func_t fn;
   rmd_src_t src;
   rmd_mode_t mode;
   rmd_act_t act;
   assign fn = rmd_func_t'(ctrl[`RMD_CTRL_FN_LSB +: 2]);
   assign src = rmd_src_t'(ctrl[`RMD_CTRL_SRC_LSB +: 2]);
   assign mode = rmd_mode_t'(ctrl[`RMD_CTRL_MODE_BIT]);
   assign act = rmd_act_t'(ctrl[`RMD_CTRL_ACT_LSB +: 2]);

   // Clamp writes into range and against each other
   always_comb begin
      next_cycle = wdata[13:0];
      if (wdata[31:14] != '0 || next_cycle > `RMD_CYCLE_MAX) next_cycle = `RMD_CYCLE_MAX; // [R04]
      if (next_cycle < min_on) next_cycle = min_on; // [R05]
      next_min_on = wdata[13:0];
      if (wdata[31:14] != '0 || next_min_on > cycle) next_min_on = cycle; // [R05] [R06]
      if (next_min_on < `RMD_MIN_ON_MIN) next_min_on = `RMD_MIN_ON_MIN; // [R06]
      next_freq = wdata[7:0];
      if (wdata[31:8] != '0 || next_freq > `RMD_FREQ_MAX) next_freq = `RMD_FREQ_MAX; // [R08]
      if (next_freq < `RMD_FREQ_MIN) next_freq = `RMD_FREQ_MIN; // [R08]
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl <= `RMD_CTRL_RST; // [R03]
         cycle <= `RMD_CYCLE_RST; // [R04]
         min_on <= `RMD_MIN_ON_RST; // [R06]
         max_freq <= `RMD_FREQ_RST; // [R08]
         diag_mode <= `RMD_DIAG_MODE_RST;
         assign_relay <= '0;
         assign_alarm <= '0;
         class_map <= '0;
      end else if (wr) begin
         case (addr)
            `RMD_ADDR_CTRL: ctrl <= wdata[6:0];
            `RMD_ADDR_CYCLE: cycle <= next_cycle;
            `RMD_ADDR_MIN_ON: min_on <= next_min_on;
            `RMD_ADDR_MAX_FREQ: max_freq <= next_freq;
            `RMD_ADDR_DIAG_MODE: diag_mode <= wdata[6:0];
            `RMD_ADDR_ASSIGN_RELAY: assign_relay <= wdata[15:0];
            `RMD_ADDR_ASSIGN_ALARM: assign_alarm <= wdata[15:0];
            `RMD_ADDR_CLASS_MAP: class_map <= wdata; // [R14]
            default: ; // Attributed list and status ignore writes [R15]
         endcase
      end
   end

   // ==========================================
   // Time base
   logic base_tick;
   logic step_tick;
   rmd_tick #(.N(BASE_TICK_CYCLES)) u_base_tick (
      .clk(clk),
      .reset(reset),
      .tick_in(1'b1),
      .tick_out(base_tick)
   );
   rmd_tick #(.N(`RMD_STEP_BASE_TICKS)) u_step_tick (
      .clk(clk),
      .reset(reset),
      .tick_in(base_tick),
      .tick_out(step_tick)
   );

   // ==========================================
   // Manipulated variable part
   rmd_y_t y_src;
   logic [9:0] y_part;
   logic sel_valid;
   always_comb begin
      case (src)
         rmd_src_c1: y_src = ctrl1_y;
         rmd_src_c2: y_src = ctrl2_y;
         default: y_src = '0;
      endcase
      sel_valid = (src == rmd_src_c1 || src == rmd_src_c2) && (act == rmd_act_neg || act == rmd_act_pos); // [R18]
      y_part = '0;
      if (act == rmd_act_pos && y_src > 0) begin
         y_part = (y_src > $signed({6'h00, `RMD_FULL_SCALE})) ? `RMD_FULL_SCALE : y_src[9:0]; // [R03]
      end else if (act == rmd_act_neg && y_src < 0) begin
         y_part = (y_src < -$signed({6'h00, `RMD_FULL_SCALE})) ? `RMD_FULL_SCALE : 10'(-y_src); // [R03]
      end
   end

   // ==========================================
   // Pulse width modulation
   logic [13:0] pwm_phase;
   logic [13:0] cyc_lat;
   logic [9:0] y_lat;
   logic [23:0] on_work;
   logic pwm_suppress;
   logic pwm_on;
   assign on_work = 24'(y_lat) * 24'(cyc_lat);
   assign pwm_suppress = on_work < 24'(min_on) * 24'(`RMD_FULL_SCALE); // [R07]
   assign pwm_on = (24'(pwm_phase) * 24'(`RMD_FULL_SCALE) < on_work) && !pwm_suppress; // [R16] [R17]

   always_ff @(posedge clk) begin
      if (reset) begin
         pwm_phase <= '0;
         cyc_lat <= `RMD_CYCLE_RST;
         y_lat <= '0;
      end else if (step_tick) begin
         if (pwm_phase + 14'h0001 >= cyc_lat) begin
            pwm_phase <= '0;
            cyc_lat <= cycle; // [R17]
            y_lat <= y_part;
         end else begin
            pwm_phase <= pwm_phase + 14'h0001;
         end
      end
   end

   // ==========================================
   // Pulse frequency modulation
   rmd_pfm_state_t pfm_state;
   logic [23:0] pfm_acc;
   logic [23:0] pfm_inc;
   logic [23:0] pfm_thr;
   always_comb begin
      if (pfm_state == rmd_pfm_pulse) begin
         pfm_inc = 24'(max_freq) * 24'(`RMD_FULL_SCALE); // [R01] [R09]
         pfm_thr = 24'(`RMD_HALF_MIN_TICKS) * 24'(`RMD_FULL_SCALE); // [R09]
      end else begin
         pfm_inc = 24'(max_freq) * 24'(y_part); // [R01]
         pfm_thr = 24'(`RMD_HALF_MIN_TICKS) * 24'(11'(2 * `RMD_FULL_SCALE) - 11'(y_part)); // [R02]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pfm_state <= rmd_pfm_gap;
         pfm_acc <= '0;
      end else if (base_tick) begin
         if (pfm_state == rmd_pfm_gap && y_part == '0) begin
            pfm_acc <= '0;
         end else if (pfm_acc + pfm_inc >= pfm_thr) begin
            pfm_acc <= '0;
            case (pfm_state)
               rmd_pfm_gap: pfm_state <= rmd_pfm_pulse; // [R16]
               rmd_pfm_pulse: pfm_state <= rmd_pfm_gap;
               default: pfm_state <= rmd_pfm_gap;
            endcase
         end else begin
            pfm_acc <= pfm_acc + pfm_inc;
         end
      end
   end

   // ==========================================
   // Diagnostics
   rmd_diag_if relay_dif ();
   rmd_diag_if alarm_dif ();
   assign relay_dif.msg_active = diag_msg_active;
   assign relay_dif.assign_mask = assign_relay;
   assign relay_dif.class_map = class_map;
   assign relay_dif.by_class = diag_mode[`RMD_DM_RELAY_LSB];
   assign relay_dif.class_sel = diag_mode[`RMD_DM_RELAY_LSB + 1 +: 2];
   assign alarm_dif.msg_active = diag_msg_active;
   assign alarm_dif.assign_mask = assign_alarm;
   assign alarm_dif.class_map = class_map;
   assign alarm_dif.by_class = diag_mode[`RMD_DM_ALARM_LSB];
   assign alarm_dif.class_sel = diag_mode[`RMD_DM_ALARM_LSB + 1 +: 2];

   rmd_diag u_relay_diag (
      .clk(clk),
      .reset(reset),
      .dif(relay_dif)
   );
   rmd_diag u_alarm_diag (
      .clk(clk),
      .reset(reset),
      .dif(alarm_dif)
   );

   // ==========================================
   // Relay drive
   logic mod_on;
   assign mod_on = sel_valid && ((mode == rmd_pfm) ? (pfm_state == rmd_pfm_pulse) : pwm_on); // [R18]

   always_ff @(posedge clk) begin
      if (reset) begin
         relay_out <= 1'b0;
      end else begin
         case (fn)
            rmd_fn_ctrl: relay_out <= mod_on; // [R16]
            rmd_fn_diag: relay_out <= !relay_dif.trip; // [R10] [R11]
            default: relay_out <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         alarm_relay_out <= 1'b0;
      end else begin
         alarm_relay_out <= !alarm_dif.trip; // [R12] [R11]
      end
   end

   // ==========================================
   // Read port
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            `RMD_ADDR_CTRL: rdata <= {25'h0000000, ctrl};
            `RMD_ADDR_CYCLE: rdata <= {18'h00000, cycle};
            `RMD_ADDR_MIN_ON: rdata <= {18'h00000, min_on};
            `RMD_ADDR_MAX_FREQ: rdata <= {24'h000000, max_freq};
            `RMD_ADDR_DIAG_MODE: rdata <= {25'h0000000, diag_mode};
            `RMD_ADDR_ASSIGN_RELAY: rdata <= {16'h0000, assign_relay};
            `RMD_ADDR_ASSIGN_ALARM: rdata <= {16'h0000, assign_alarm};
            `RMD_ADDR_CLASS_MAP: rdata <= class_map;
            `RMD_ADDR_ATTRIB: rdata <= {assign_alarm, assign_relay}; // [R15]
            `RMD_ADDR_STATUS: rdata <= {26'h0000000, pfm_state == rmd_pfm_pulse, mod_on, alarm_dif.trip,
                                        relay_dif.trip, alarm_relay_out, relay_out};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   // ==========================================
   // Checks
   logic [11:0] pulse_len;
   logic freq_dirty;
   always_ff @(posedge clk) begin
      if (reset || pfm_state == rmd_pfm_gap) begin
         pulse_len <= '0;
         freq_dirty <= 1'b0;
      end else begin
         pulse_len <= pulse_len + 12'(base_tick);
         freq_dirty <= freq_dirty || (wr && addr == `RMD_ADDR_MAX_FREQ);
      end
   end

   property p_cycle_order;
      @(posedge clk) disable iff (reset) cycle >= min_on;
   endproperty
   a_cycle_order: assert property (p_cycle_order) else $error("cycle below minimum on-time"); // [R05]

   property p_ranges;
      @(posedge clk) disable iff (reset)
         cycle <= `RMD_CYCLE_MAX && min_on >= `RMD_MIN_ON_MIN && max_freq >= `RMD_FREQ_MIN && max_freq <= `RMD_FREQ_MAX;
   endproperty
   a_ranges: assert property (p_ranges) else $error("setting out of range"); // [R04]

   property p_suppress;
      @(posedge clk) disable iff (reset)
         (fn == rmd_fn_ctrl && mode == rmd_pwm && pwm_suppress) |=> !relay_out;
   endproperty
   a_suppress: assert property (p_suppress) else $error("short pulse was output"); // [R07]

   property p_none_off;
      @(posedge clk) disable iff (reset) (fn == rmd_fn_ctrl && !sel_valid) |=> !relay_out;
   endproperty
   a_none_off: assert property (p_none_off) else $error("relay on without source"); // [R18]

   property p_alarm_failsafe;
      @(posedge clk) disable iff (reset) !$past(reset) |-> (alarm_relay_out == !$past(alarm_dif.trip));
   endproperty
   a_alarm_failsafe: assert property (p_alarm_failsafe) else $error("alarm relay not fail-safe"); // [R12]

   property p_diag_failsafe;
      @(posedge clk) disable iff (reset) (fn == rmd_fn_diag && relay_dif.trip) |=> !relay_out;
   endproperty
   a_diag_failsafe: assert property (p_diag_failsafe) else $error("diag relay held on error"); // [R11]

   property p_attrib_ro;
      @(posedge clk) disable iff (reset)
         (wr && addr == `RMD_ADDR_ATTRIB) |=> $stable(assign_relay) && $stable(assign_alarm);
   endproperty
   a_attrib_ro: assert property (p_attrib_ro) else $error("attributed list was written"); // [R15]

   property p_pulse_len;
      @(posedge clk) disable iff (reset)
         ($fell(pfm_state == rmd_pfm_pulse) && $stable(max_freq) && !freq_dirty) |->
            (20'($past(pulse_len) + 12'h001) * 20'(max_freq) >= 20'(`RMD_HALF_MIN_TICKS)) &&
            (20'($past(pulse_len)) * 20'(max_freq) < 20'(`RMD_HALF_MIN_TICKS));
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length off rate"); // [R09]
endmodule : rmd_top
`default_nettype wire

// ===== bench/rmd_actuator.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Actuator coil: times each pulse and pause
module rmd_actuator (
   input wire logic clk,
   input wire logic reset,
   input wire logic coil,
   output var int unsigned on_len,
   output var int unsigned off_len,
   output var int unsigned rises
);
   logic coil_q;
   int unsigned cnt;

   always_ff @(posedge clk) begin
      if (reset) begin
         coil_q <= 1'b0;
         cnt <= 0;
         rises <= 0;
         on_len <= 0;
         off_len <= 0;
      end else begin
         coil_q <= coil;
         if (coil !== coil_q) begin
            cnt <= 1;
            if (coil === 1'b1) begin
               off_len <= cnt;
               rises <= rises + 1;
            end else begin
               on_len <= cnt;
            end
         end else begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : rmd_actuator
`default_nettype wire

// ===== bench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rmd_map.svh"
module tb;
   import rmd_pkg::*;
   localparam int unsigned bt_cycles = 4;
   localparam int unsigned step_cycles = bt_cycles * `RMD_STEP_BASE_TICKS;
   localparam rmd_word_t full_mask = 32'hffffffff;
   typedef struct {string name; rmd_word_t val; rmd_word_t mask;} rmd_note_t;

   logic clk, reset, wr, rd, relay_out, alarm_relay_out, rd_prev, tr, ta;
   rmd_addr_t addr;
   rmd_word_t wdata, rdata, map, fn;
   rmd_y_t ctrl1_y, ctrl2_y;
   rmd_msg_t diag_msg_active, msg, mr, ma;
   logic [6:0] dm;
   int unsigned on_len, off_len, rises;
   int failures, cmp_count;
   rmd_note_t exp_q [$];
   rmd_note_t note;
   rmd_addr_t rst_addr [9] = '{`RMD_ADDR_CTRL, `RMD_ADDR_CYCLE, `RMD_ADDR_MIN_ON, `RMD_ADDR_MAX_FREQ,
      `RMD_ADDR_DIAG_MODE, `RMD_ADDR_ASSIGN_RELAY, `RMD_ADDR_ASSIGN_ALARM, `RMD_ADDR_CLASS_MAP, 8'h30};
   rmd_word_t rst_val [9] = '{32'h0, 32'h64, 32'h3, 32'h3c, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

   rmd_top #(.BASE_TICK_CYCLES(bt_cycles)) dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ctrl1_y(ctrl1_y), .ctrl2_y(ctrl2_y),
      .diag_msg_active(diag_msg_active), .relay_out(relay_out), .alarm_relay_out(alarm_relay_out));

   rmd_actuator u_act (.clk(clk), .reset(reset), .coil(relay_out), .on_len(on_len), .off_len(off_len),
      .rises(rises));

   always #20 clk = ~clk;

   // ==========================================
   // Checking
   task automatic cmp(input string name, input rmd_word_t exp, input rmd_word_t got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : cmp

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize

   // Read data stands only in the cycle after the strobe
   always @(posedge clk) rd_prev <= rd;
   always @(negedge clk) begin
      if (rd_prev === 1'b1) begin
         if (exp_q.size() == 0) begin
            failures++;
            $display("mismatch read_note expected 1 seen 0");
         end else begin
            note = exp_q.pop_front();
            cmp(note.name, note.val & note.mask, rdata & note.mask);
         end
      end
   end

   function automatic logic trip_of(input rmd_msg_t m, input rmd_msg_t as, input rmd_word_t cm, input logic bc,
                                    input logic [1:0] c);
      logic t;
      t = 1'b0;
      for (int j = 0; j < 16; j++) begin
         if (m[j] && (bc ? (cm[2*j +: 2] == c) : as[j])) begin
            t = 1'b1;
         end
      end
      return t;
   endfunction : trip_of

   // ==========================================
   // Register bus
   task automatic wr_reg(input rmd_addr_t a, input rmd_word_t d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input rmd_addr_t a, input rmd_word_t e, input rmd_word_t m, input string n);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back('{n, e, m});
      @(posedge clk);
      rd <= 1'b0;
   endtask : rd_reg

   // ==========================================
   // Relay traffic
   task automatic measure(input int unsigned n);
      int unsigned r0;
      int k;
      r0 = rises;
      k = 0;
      while (rises < r0 + n && k < 40000) begin
         @(posedge clk);
         k++;
      end
      if (k >= 40000) begin
         failures++;
         $display("mismatch relay_pulses expected %0d seen %0d", r0 + n, rises);
         summarize();
      end
      @(negedge clk);
   endtask : measure

   task automatic run_mod(input rmd_word_t c, input rmd_y_t y1, input rmd_y_t y2, input int unsigned t_on,
                          input int unsigned t_off);
      wr_reg(`RMD_ADDR_CTRL, c);
      ctrl1_y <= y1;
      ctrl2_y <= y2;
      measure(3);
      cmp("pulse_on_time", t_on, on_len);
      cmp("pulse_off_interval", t_off, off_len);
   endtask : run_mod

   task automatic quiet(input rmd_word_t c, input rmd_y_t y1);
      int unsigned r0;
      wr_reg(`RMD_ADDR_CTRL, c);
      ctrl1_y <= y1;
      repeat (30 * step_cycles) @(posedge clk);
      r0 = rises;
      repeat (60 * step_cycles) @(posedge clk);
      cmp("quiet_rises", 32'h0, rises - r0);
      cmp("quiet_relay", 32'h0, {31'h0, relay_out});
   endtask : quiet

   // ==========================================
   // Main sequence
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      addr = '0;
      wdata = '0;
      wr = 1'b0;
      rd = 1'b0;
      ctrl1_y = '0;
      ctrl2_y = '0;
      diag_msg_active = '0;
      failures = 0;
      cmp_count = 0;
      void'($urandom(85));
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd_reg(rst_addr[i], rst_val[i], full_mask, "reset_value");
      end
      wr_reg(`RMD_ADDR_CYCLE, 32'h0000ffff);
      rd_reg(`RMD_ADDR_CYCLE, 32'h00002706, full_mask, "cycle_max");
      wr_reg(`RMD_ADDR_MIN_ON, 32'h00000000);
      rd_reg(`RMD_ADDR_MIN_ON, 32'h00000003, full_mask, "min_on_floor");
      wr_reg(`RMD_ADDR_CYCLE, 32'h00000001);
      rd_reg(`RMD_ADDR_CYCLE, 32'h00000003, full_mask, "cycle_floor");
      wr_reg(`RMD_ADDR_CYCLE, 32'h00000014);
      wr_reg(`RMD_ADDR_MIN_ON, 32'h000000ff);
      rd_reg(`RMD_ADDR_MIN_ON, 32'h00000014, full_mask, "min_on_ceiling");
      wr_reg(`RMD_ADDR_MIN_ON, 32'h00000003);
      wr_reg(`RMD_ADDR_MAX_FREQ, 32'h00000000);
      rd_reg(`RMD_ADDR_MAX_FREQ, 32'h00000001, full_mask, "freq_floor");
      wr_reg(`RMD_ADDR_MAX_FREQ, 32'h000000c8);
      rd_reg(`RMD_ADDR_MAX_FREQ, 32'h000000b4, full_mask, "freq_ceiling");
      wr_reg(`RMD_ADDR_MAX_FREQ, 32'h0000003c);
      run_mod(32'h45, 16'sd500, -16'sd500, 10 * step_cycles, 10 * step_cycles);
      run_mod(32'h45, 16'sd150, 16'sd0, 3 * step_cycles, 17 * step_cycles);
      run_mod(32'h29, 16'sd500, -16'sd250, 5 * step_cycles, 15 * step_cycles);
      run_mod(32'h55, 16'sd1000, 16'sd0, 50 * bt_cycles, 50 * bt_cycles);
      run_mod(32'h55, 16'sd500, 16'sd0, 50 * bt_cycles, 150 * bt_cycles);
      wr_reg(`RMD_ADDR_MAX_FREQ, 32'h000000b4);
      run_mod(32'h55, 16'sd1000, 16'sd0, 17 * bt_cycles, 17 * bt_cycles);
      quiet(32'h45, 16'sd140);
      quiet(32'h41, 16'sd800);
      quiet(32'h05, 16'sd800);
      for (int i = 0; i < 8; i++) begin
         msg = (i == 0) ? 16'h0000 : 16'($urandom & $urandom & $urandom);
         mr = 16'($urandom);
         ma = 16'($urandom);
         map = $urandom;
         dm = 7'($urandom);
         fn = i[0] ? 32'h0 : 32'h2;
         diag_msg_active <= msg;
         wr_reg(`RMD_ADDR_CTRL, fn);
         wr_reg(`RMD_ADDR_ASSIGN_RELAY, {16'h0, mr});
         wr_reg(`RMD_ADDR_ASSIGN_ALARM, {16'h0, ma});
         wr_reg(`RMD_ADDR_CLASS_MAP, map);
         wr_reg(`RMD_ADDR_DIAG_MODE, {25'h0, dm});
         wr_reg(`RMD_ADDR_ATTRIB, $urandom);
         tr = trip_of(msg, mr, map, dm[0], dm[2:1]);
         ta = trip_of(msg, ma, map, dm[4], dm[6:5]);
         rd_reg(`RMD_ADDR_ATTRIB, {ma, mr}, full_mask, "attributed_list");
         rd_reg(`RMD_ADDR_STATUS, {28'h0, ta, tr, ~ta, ~tr & fn[1]}, 32'h0000000f,
                "diag_status");
      end
      repeat (3) @(posedge clk);
      cmp("rdata_idle", 32'h0, rdata);
      summarize();
   end
endmodule : tb
`default_nettype wire
